// file: antenna_supply_supervisor.sv
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
// Notes on behaviour
// - supply control enable reads 1 after reset
// - state published in report always, in notices only while supply control enabled
// - short sense evaluated only while short detect enabled
// - short sense active level set by short polarity bit
// - short with power down enabled drops amplifier enable while supply control enabled
// - short stays reported until reset, detect disable, or retry clears it
// - auto-retry restores supply after 60 s and keeps it if no short
// - auto-retry only while retry enable is 1
// - open sense evaluated only while open detect enabled
// - open sense active level can be inverted
// - state codes: 00 init, 01 unknown, 02 ok, 03 short, 04 open
// - power codes: 00 off, 01 on, 02 unknown when supply control off
// - power off when processing stopped or short with power down
// - power on while processing runs, unless short with power down
// - short outranks open
// - supply control on, processing on and no fault gives ok with power on
// - open means low current, short means excess current, per sense lines
// - start: feature notice, then init notice, then current state notice
// - state notice on each change, naming ok, short or open
module antenna_supply_supervisor #(
  parameter logic [35:0] RetryCycles = 36'(antenna_supervisor_pkg::RETRY_CYCLES)
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        shortSense,
  input  wire logic        openSense,
  input  wire logic        processingOn,
  output logic             amplifierEnableOut,
  output logic             antennaOff,
  output logic             noticeValid,
  output logic             noticeKind,
  output logic [7:0]       noticeData
);

  // ----------------------------------------
  // configuration
  // ----------------------------------------
  logic [antenna_supervisor_pkg::CFG_W-1:0] config_r;
  logic supplyEn;
  logic shortEn;
  logic pwrDownEn;
  logic retryEn;
  logic openEn;

  assign supplyEn  = config_r[antenna_supervisor_pkg::CFG_SUPPLY];
  assign shortEn   = config_r[antenna_supervisor_pkg::CFG_SHORT];
  assign pwrDownEn = config_r[antenna_supervisor_pkg::CFG_PWRDOWN];
  assign retryEn   = config_r[antenna_supervisor_pkg::CFG_RETRY];
  assign openEn    = config_r[antenna_supervisor_pkg::CFG_OPEN];

  // ----------------------------------------
  // sense inputs
  // ----------------------------------------
  logic shortFault;
  logic openFault;

  sense_qualifier u_short (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .enable   (shortEn),
    .polarity (config_r[antenna_supervisor_pkg::CFG_SHORTPOL]),
    .raw      (shortSense),
    .fault    (shortFault)
  );

  sense_qualifier u_open (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .enable   (openEn),
    .polarity (config_r[antenna_supervisor_pkg::CFG_OPENPOL]),
    .raw      (openSense),
    .fault    (openFault)
  );

  // ----------------------------------------
  // short latch and auto-retry
  // ----------------------------------------
  logic shortLatched_r;
  logic retryExpire;

  retry_timer #(
    .W      (36),
    .CYCLES (RetryCycles)
  ) u_retry (
    .clk    (clk),
    .rst    (rst),
    .ce     (ce),
    .run    (shortLatched_r & retryEn),
    .expire (retryExpire)
  );

  // expiry drops the latch unless a short is sensed that cycle, so supply comes back;
  // a short sensed once supply returns relatches it and the timeout starts over
  always_ff @(posedge clk) begin
    if (rst) begin
      shortLatched_r <= 1'b0;
    end else if (ce) begin
      if (shortFault) begin
        shortLatched_r <= 1'b1;
      end else if (!shortEn || retryExpire) begin
        shortLatched_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // supply switching
  // ----------------------------------------
  logic supplyOff;
  assign supplyOff = supplyEn & ((shortLatched_r & pwrDownEn) | ~processingOn);

  always_ff @(posedge clk) begin
    if (rst) begin
      antennaOff         <= 1'b0;
      amplifierEnableOut <= 1'b1;
    end else if (ce) begin
      antennaOff         <= supplyOff;
      amplifierEnableOut <= ~supplyOff;
    end
  end

  // ----------------------------------------
  // state and power codes
  // ----------------------------------------
  antenna_supervisor_pkg::seq_t        seq_r;
  antenna_supervisor_pkg::seq_t        seq_nxt;
  antenna_supervisor_pkg::state_code_t liveCode;
  antenna_supervisor_pkg::state_code_t stateCode;
  antenna_supervisor_pkg::power_code_t powerCode;

  always_comb begin
    if (shortLatched_r) begin
      liveCode = antenna_supervisor_pkg::ST_SHORT;
    end else if (openFault) begin
      liveCode = antenna_supervisor_pkg::ST_OPEN;
    end else if (supplyEn) begin
      liveCode = antenna_supervisor_pkg::ST_OK;
    end else begin
      liveCode = antenna_supervisor_pkg::ST_UNKNOWN;
    end
  end

  always_comb begin
    if (supplyEn && seq_r != antenna_supervisor_pkg::SEQ_RUN) begin
      stateCode = antenna_supervisor_pkg::ST_INIT;
    end else begin
      stateCode = liveCode;
    end
  end

  always_comb begin
    if (!supplyEn) begin
      powerCode = antenna_supervisor_pkg::PWR_UNKNOWN;
    end else if (supplyOff) begin
      powerCode = antenna_supervisor_pkg::PWR_OFF;
    end else begin
      powerCode = antenna_supervisor_pkg::PWR_ON;
    end
  end

  logic [7:0] stateCode_r;
  logic [7:0] powerCode_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      stateCode_r <= antenna_supervisor_pkg::ST_INIT;
      powerCode_r <= antenna_supervisor_pkg::PWR_ON;
    end else if (ce) begin
      stateCode_r <= stateCode;
      powerCode_r <= powerCode;
    end
  end

  // ----------------------------------------
  // notice sequencing
  // ----------------------------------------
  logic [7:0] lastCode_r;
  logic [7:0] features;

  always_comb begin
    features = 8'h00;
    features[antenna_supervisor_pkg::VOLTAGE_FEATURE_TAG]    = supplyEn;
    features[antenna_supervisor_pkg::SHORT_FEATURE_TAG]      = shortEn;
    features[antenna_supervisor_pkg::OPEN_FEATURE_TAG]       = openEn;
    features[antenna_supervisor_pkg::POWER_DOWN_FEATURE_TAG] = pwrDownEn;
    features[antenna_supervisor_pkg::RETRY_FEATURE_TAG]      = retryEn;
  end

  always_comb begin
    case (seq_r)
      antenna_supervisor_pkg::SEQ_IDLE: seq_nxt = antenna_supervisor_pkg::SEQ_FEAT;
      antenna_supervisor_pkg::SEQ_FEAT: seq_nxt = antenna_supervisor_pkg::SEQ_INIT;
      antenna_supervisor_pkg::SEQ_INIT: seq_nxt = antenna_supervisor_pkg::SEQ_RUN;
      default:                          seq_nxt = antenna_supervisor_pkg::SEQ_RUN;
    endcase
    if (!supplyEn) begin
      seq_nxt = antenna_supervisor_pkg::SEQ_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      seq_r <= antenna_supervisor_pkg::SEQ_IDLE;
    end else if (ce) begin
      seq_r <= seq_nxt;
    end
  end

  // notices stay silent while supply control is off
  always_ff @(posedge clk) begin
    if (rst) begin
      noticeValid <= 1'b0;
      noticeKind  <= antenna_supervisor_pkg::NOTICE_FEATURE;
      noticeData  <= 8'h00;
      lastCode_r  <= antenna_supervisor_pkg::ST_INIT;
    end else if (ce) begin
      noticeValid <= 1'b0;
      if (supplyEn) begin
        case (seq_r)
          antenna_supervisor_pkg::SEQ_FEAT: begin
            noticeValid <= 1'b1;
            noticeKind  <= antenna_supervisor_pkg::NOTICE_FEATURE;
            noticeData  <= features;
          end
          antenna_supervisor_pkg::SEQ_INIT: begin
            noticeValid <= 1'b1;
            noticeKind  <= antenna_supervisor_pkg::NOTICE_STATE;
            noticeData  <= antenna_supervisor_pkg::ST_INIT;
            lastCode_r  <= antenna_supervisor_pkg::ST_INIT;
          end
          antenna_supervisor_pkg::SEQ_RUN: begin
            if (liveCode != lastCode_r) begin
              noticeValid <= 1'b1;
              noticeKind  <= antenna_supervisor_pkg::NOTICE_STATE;
              noticeData  <= liveCode;
              lastCode_r  <= liveCode;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // apb slave, no wait states
  // ----------------------------------------
  logic       setup;
  logic       access;
  logic       mapped;
  logic [8:0] lastNotice_r;

  assign setup  = psel & ~penable;
  assign access = psel & penable & pready;
  assign mapped = (paddr == antenna_supervisor_pkg::ADDR_CONFIG)
                | (paddr == antenna_supervisor_pkg::ADDR_STATUS)
                | (paddr == antenna_supervisor_pkg::ADDR_NOTICE);

  always_ff @(posedge clk) begin
    if (rst) begin
      lastNotice_r <= 9'h000;
    end else if (ce && noticeValid) begin
      lastNotice_r <= {noticeKind, noticeData};
    end
  end

  // read data is loaded in setup so that pready and prdata leave flops
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (setup && !pwrite) begin
        if (paddr == antenna_supervisor_pkg::ADDR_CONFIG) begin
          prdata <= {25'h000_0000, config_r};
        end else if (paddr == antenna_supervisor_pkg::ADDR_STATUS) begin
          prdata <= {16'h0000, powerCode_r, stateCode_r};
        end else if (paddr == antenna_supervisor_pkg::ADDR_NOTICE) begin
          prdata <= {23'h00_0000, lastNotice_r};
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      config_r <= antenna_supervisor_pkg::CFG_RESET;
    end else if (ce && access && pwrite
                 && paddr == antenna_supervisor_pkg::ADDR_CONFIG) begin
      config_r <= pwdata[antenna_supervisor_pkg::CFG_W-1:0];
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_short_reported: assert property (@(posedge clk) disable iff (rst)
    ce && shortLatched_r
    && (!supplyEn || seq_r == antenna_supervisor_pkg::SEQ_RUN)
    |=> stateCode_r == antenna_supervisor_pkg::ST_SHORT)
    else $error("latched short not reported as short");

  a_power_down_drop: assert property (@(posedge clk) disable iff (rst)
    ce && supplyEn && pwrDownEn && shortLatched_r |=> !amplifierEnableOut)
    else $error("amplifier still enabled during short");

  a_off_pairs_enable: assert property (@(posedge clk) disable iff (rst)
    antennaOff == !amplifierEnableOut)
    else $error("supply off and amplifier enable disagree");

  a_short_needs_enable: assert property (@(posedge clk) disable iff (rst)
    ce && !shortEn |=> !shortFault)
    else $error("short sensed with detection off");

  a_latch_held: assert property (@(posedge clk) disable iff (rst)
    ce && shortLatched_r && shortEn && !retryExpire |=> shortLatched_r)
    else $error("short latch dropped without cause");

  a_power_unknown: assert property (@(posedge clk) disable iff (rst)
    ce && !supplyEn |=> powerCode_r == antenna_supervisor_pkg::PWR_UNKNOWN)
    else $error("power code not unknown with supply control off");

  a_notice_order: assert property (@(posedge clk) disable iff (rst)
    ce && supplyEn && seq_r == antenna_supervisor_pkg::SEQ_FEAT
    ##1 ce && supplyEn
    |=> noticeValid && noticeKind == antenna_supervisor_pkg::NOTICE_STATE
        && noticeData == antenna_supervisor_pkg::ST_INIT)
    else $error("init notice does not follow feature notice");

  a_notice_silent: assert property (@(posedge clk) disable iff (rst)
    ce && !supplyEn |=> !noticeValid)
    else $error("notice emitted with supply control off");

  a_no_retry_off: assert property (@(posedge clk) disable iff (rst)
    ce && !retryEn |=> !retryExpire)
    else $error("retry expired while retry disabled");

  a_ok_power_on: assert property (@(posedge clk) disable iff (rst)
    ce && supplyEn && processingOn && !shortLatched_r && !openFault
    && seq_r == antenna_supervisor_pkg::SEQ_RUN
    |=> stateCode_r == antenna_supervisor_pkg::ST_OK
        && powerCode_r == antenna_supervisor_pkg::PWR_ON)
    else $error("no fault but not ok and on");

endmodule

// file: antenna_supervisor_pkg.sv
package antenna_supervisor_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam longint unsigned CLK_HZ       = 64'd100_000_000;
  localparam longint unsigned RETRY_TIME_S = 64'd60;
  localparam longint unsigned RETRY_CYCLES = RETRY_TIME_S * CLK_HZ;
  localparam int              TIMER_W      = 36;

  // ----------------------------------------
  // register map, byte addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_NOTICE = 8'h08;

  // config field positions
  localparam int CFG_SUPPLY   = 0;
  localparam int CFG_SHORT    = 1;
  localparam int CFG_SHORTPOL = 2;
  localparam int CFG_PWRDOWN  = 3;
  localparam int CFG_RETRY    = 4;
  localparam int CFG_OPEN     = 5;
  localparam int CFG_OPENPOL  = 6;
  localparam int CFG_W        = 7;
  localparam logic [CFG_W-1:0] CFG_RESET = 7'h01;

  // feature tag bit positions in a feature notice
  localparam int VOLTAGE_FEATURE_TAG    = 0;
  localparam int SHORT_FEATURE_TAG      = 1;
  localparam int OPEN_FEATURE_TAG       = 2;
  localparam int POWER_DOWN_FEATURE_TAG = 3;
  localparam int RETRY_FEATURE_TAG      = 4;

  // ----------------------------------------
  // codes
  // ----------------------------------------
  typedef enum logic [7:0] {
    ST_INIT    = 8'h00,
    ST_UNKNOWN = 8'h01,
    ST_OK      = 8'h02,
    ST_SHORT   = 8'h03,
    ST_OPEN    = 8'h04
  } state_code_t;

  typedef enum logic [7:0] {
    PWR_OFF     = 8'h00,
    PWR_ON      = 8'h01,
    PWR_UNKNOWN = 8'h02
  } power_code_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_FEAT = 2'b01,
    SEQ_INIT = 2'b10,
    SEQ_RUN  = 2'b11
  } seq_t;

  localparam logic NOTICE_FEATURE = 1'b0;
  localparam logic NOTICE_STATE   = 1'b1;

  typedef struct packed {
    logic       kind;
    logic [7:0] data;
  } notice_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

endpackage

// file: sense_qualifier.sv
`timescale 1ns/1ps
module sense_qualifier (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic enable,
  input  wire logic polarity,
  input  wire logic raw,
  output logic      fault
);
  // polarity high: sense line active high; masked while detection is off
  always_ff @(posedge clk) begin
    if (rst) begin
      fault <= 1'b0;
    end else if (ce) begin
      fault <= enable & (raw ~^ polarity);
    end
  end
endmodule

// file: retry_timer.sv
`timescale 1ns/1ps
module retry_timer #(
  parameter int                      W      = antenna_supervisor_pkg::TIMER_W,
  parameter logic [W-1:0]            CYCLES = W'(antenna_supervisor_pkg::RETRY_CYCLES)
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic run,
  output logic      expire
);
  logic [W-1:0] count_r;

  // dropping run zeroes the count, so each new run starts a fresh timeout
  always_ff @(posedge clk) begin
    if (rst) begin
      count_r <= '0;
      expire  <= 1'b0;
    end else if (ce) begin
      expire <= 1'b0;
      if (!run) begin
        count_r <= '0;
      end else if (count_r == CYCLES - W'(1)) begin
        count_r <= '0;
        expire  <= 1'b1;
      end else begin
        count_r <= count_r + W'(1);
      end
    end
  end
endmodule

// file: antenna_circuit_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// active antenna supply and external amplifier
// ----------------------------------------
module antenna_circuit_model (
  input  wire logic clk,
  input  wire logic amplifierEnableOut,
  input  wire logic shortMode,
  input  wire logic openMode,
  input  wire logic shortHigh,
  input  wire logic openHigh,
  output logic      shortSense,
  output logic      openSense
);
  // excess current only while supplied; unpowered antenna draws nothing
  always @(posedge clk) begin
    shortSense <= (shortMode && amplifierEnableOut) ~^ shortHigh;
    openSense  <= (openMode || !amplifierEnableOut) ~^ openHigh;
  end
endmodule

// file: tb.sv
`timescale 1ns/1ps
module tb;
  // ----------------------------------------
  // constants and signals
  // ----------------------------------------
  localparam logic [35:0] RETRY = 36'h0_0000_0014;
  localparam logic [31:0] SUP   = 32'h0000_0001 << antenna_supervisor_pkg::CFG_SUPPLY;
  localparam logic [31:0] SHD   = 32'h0000_0001 << antenna_supervisor_pkg::CFG_SHORT;
  localparam logic [31:0] SPOL  = 32'h0000_0001 << antenna_supervisor_pkg::CFG_SHORTPOL;
  localparam logic [31:0] PDN   = 32'h0000_0001 << antenna_supervisor_pkg::CFG_PWRDOWN;
  localparam logic [31:0] RTY   = 32'h0000_0001 << antenna_supervisor_pkg::CFG_RETRY;
  localparam logic [31:0] OPD   = 32'h0000_0001 << antenna_supervisor_pkg::CFG_OPEN;
  localparam logic [31:0] OPOL  = 32'h0000_0001 << antenna_supervisor_pkg::CFG_OPENPOL;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        shortSense;
  logic        openSense;
  logic        processingOn = 1'b1;
  logic        amplifierEnableOut;
  logic        antennaOff;
  logic        noticeValid;
  logic        noticeKind;
  logic [7:0]  noticeData;
  logic        shortMode = 1'b0;
  logic        openMode = 1'b0;
  logic        shortHigh = 1'b0;
  logic        openHigh = 1'b0;
  logic [31:0] rd;
  logic        err;
  logic [8:0]  notes[$];
  int          mismatches = 0;
  int          nCompared = 0;
  int          cycles = 0;

  antenna_supply_supervisor #(.RetryCycles(RETRY)) i_antenna_supply_supervisor (
    .clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shortSense(shortSense), .openSense(openSense), .processingOn(processingOn),
    .amplifierEnableOut(amplifierEnableOut), .antennaOff(antennaOff),
    .noticeValid(noticeValid), .noticeKind(noticeKind), .noticeData(noticeData));

  antenna_circuit_model i_antenna_circuit_model (
    .clk(clk), .amplifierEnableOut(amplifierEnableOut), .shortMode(shortMode),
    .openMode(openMode), .shortHigh(shortHigh), .openHigh(openHigh),
    .shortSense(shortSense), .openSense(openSense));

  always #5 clk = ~clk;

  // notice pulses last one cycle, so collect every one of them
  always @(posedge clk) begin
    cycles++;
    if (noticeValid === 1'b1) notes.push_back({noticeKind, noticeData});
    if (cycles == 5000) begin
      mismatches++;
      close_out();
    end
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic close_out();
    if (mismatches == 0 && nCompared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nCompared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // idle edge first so psel is never assigned twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50) mismatches++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cfg(input logic [31:0] v);
    apb(1'b1, antenna_supervisor_pkg::ADDR_CONFIG, v);
  endtask

  task automatic status(input string what, input logic [15:0] exp);
    apb(1'b0, antenna_supervisor_pkg::ADDR_STATUS, 32'h0000_0000);
    chk(what, {16'h0000, exp}, rd);
  endtask

  task automatic supply(input logic [1:0] exp);
    chk("amp/off", {30'h0000_0000, exp}, {30'h0000_0000, amplifierEnableOut, antennaOff});
  endtask

  task automatic note(input logic k, input logic [7:0] d);
    int n;
    n = 0;
    while (notes.size() == 0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk("notice", {23'h00_0000, k, d},
        notes.size() ? {23'h00_0000, notes.pop_front()} : 32'hxxxx_xxxx);
  endtask

  task automatic settle();
    repeat (8) @(posedge clk);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    note(1'b0, 8'h01);
    note(1'b1, 8'h00);
    note(1'b1, 8'h02);
    apb(1'b0, antenna_supervisor_pkg::ADDR_CONFIG, 32'h0000_0000);
    chk("config", 32'h0000_0001, rd);
    status("status", {antenna_supervisor_pkg::PWR_ON, antenna_supervisor_pkg::ST_OK});
    supply(2'b10);
    apb(1'b1, 8'h0C, 32'h0000_007E);
    chk("slverr", 32'h0000_0001, {31'h0000_0000, err});
    apb(1'b0, antenna_supervisor_pkg::ADDR_CONFIG, 32'h0000_0000);
    chk("config kept", 32'h0000_0001, rd);
  endtask

  task automatic t_features();
    cfg(32'h0000_0000);
    settle();
    notes.delete();
    status("off", {antenna_supervisor_pkg::PWR_UNKNOWN, antenna_supervisor_pkg::ST_UNKNOWN});
    chk("quiet", 32'h0000_0000, 32'(notes.size()));
    cfg(SUP | SHD | PDN | RTY | OPD);
    note(1'b0, 8'h1F);
    note(1'b1, 8'h00);
    note(1'b1, 8'h02);
    apb(1'b0, antenna_supervisor_pkg::ADDR_NOTICE, 32'h0000_0000);
    chk("last notice", 32'h0000_0102, rd);
  endtask

  // active-low sense lines; supply off also makes the open line fire
  task automatic t_short();
    cfg(SUP | SHD | PDN | OPD);
    settle();
    notes.delete();
    shortMode <= 1'b1;
    settle();
    supply(2'b01);
    status("short", {antenna_supervisor_pkg::PWR_OFF, antenna_supervisor_pkg::ST_SHORT});
    note(1'b1, 8'h03);
    shortMode <= 1'b0;
    openMode <= 1'b1;
    repeat (40) @(posedge clk);
    status("held", {antenna_supervisor_pkg::PWR_OFF, antenna_supervisor_pkg::ST_SHORT});
    openMode <= 1'b0;
    cfg(SUP | PDN | OPD);
    cfg(SUP | SHD | PDN | OPD);
    settle();
    status("rearm", {antenna_supervisor_pkg::PWR_ON, antenna_supervisor_pkg::ST_OK});
    supply(2'b10);
  endtask

  task automatic t_open();
    cfg(SUP);
    shortHigh <= 1'b1;
    openHigh <= 1'b1;
    cfg(SUP | SHD | SPOL | OPD | OPOL);
    settle();
    notes.delete();
    openMode <= 1'b1;
    settle();
    status("open", {antenna_supervisor_pkg::PWR_ON, antenna_supervisor_pkg::ST_OPEN});
    note(1'b1, 8'h04);
    shortMode <= 1'b1;
    settle();
    status("no pd", {antenna_supervisor_pkg::PWR_ON, antenna_supervisor_pkg::ST_SHORT});
    supply(2'b10);
    shortMode <= 1'b0;
    openMode <= 1'b0;
  endtask

  task automatic t_nodetect();
    cfg(SUP);
    settle();
    notes.delete();
    shortMode <= 1'b1;
    openMode <= 1'b1;
    settle();
    status("ignored", {antenna_supervisor_pkg::PWR_ON, antenna_supervisor_pkg::ST_OK});
    chk("quiet", 32'h0000_0000, 32'(notes.size()));
    shortMode <= 1'b0;
    openMode <= 1'b0;
  endtask

  task automatic t_retry();
    int n;
    n = 0;
    cfg(SUP | SHD | SPOL | PDN | RTY);
    settle();
    shortMode <= 1'b1;
    settle();
    supply(2'b01);
    repeat (60) @(posedge clk);
    shortMode <= 1'b0;
    while (amplifierEnableOut !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    settle();
    supply(2'b10);
    status("retried", {antenna_supervisor_pkg::PWR_ON, antenna_supervisor_pkg::ST_OK});
  endtask

  task automatic t_nosupply();
    cfg(SHD | SPOL);
    settle();
    notes.delete();
    shortMode <= 1'b1;
    settle();
    status("uncontrolled", {antenna_supervisor_pkg::PWR_UNKNOWN, antenna_supervisor_pkg::ST_SHORT});
    supply(2'b10);
    chk("quiet", 32'h0000_0000, 32'(notes.size()));
    shortMode <= 1'b0;
    cfg(SUP);
    settle();
    processingOn <= 1'b0;
    settle();
    status("stopped", {antenna_supervisor_pkg::PWR_OFF, antenna_supervisor_pkg::ST_OK});
    supply(2'b01);
    processingOn <= 1'b1;
  endtask

  // clock enable low must hold off the short until it is raised again
  task automatic t_freeze();
    cfg(SUP | SHD | SPOL | PDN);
    settle();
    ce <= 1'b0;
    shortMode <= 1'b1;
    settle();
    supply(2'b10);
    ce <= 1'b1;
    settle();
    supply(2'b01);
    shortMode <= 1'b0;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_features();
    t_short();
    t_open();
    t_nodetect();
    t_retry();
    t_freeze();
    t_nosupply();
    close_out();
  end
endmodule
